/* File: logic/bbx_pkg.sv */
`default_nettype none

package bbx_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] BBX_OFS_INSTR = 12'h000;
  localparam logic [11:0] BBX_OFS_W = 12'h004;
  localparam logic [11:0] BBX_OFS_STATUS = 12'h008;
  localparam logic [11:0] BBX_OFS_CFG = 12'h00c;
  localparam logic [11:0] BBX_OFS_CYCLES = 12'h010;
  localparam logic [11:0] BBX_OFS_PINS = 12'h014;
  // file window: base + 4 * file address, 128 words
  localparam logic [2:0] BBX_FILE_WIN_TOP = 3'h1;

  // ---------------------------------------------------------------
  // instruction word fields
  // ---------------------------------------------------------------
  localparam int BBX_INSTR_K_LSB = 0;
  localparam int BBX_INSTR_F_LSB = 8;
  localparam int BBX_INSTR_B_LSB = 15;
  localparam int BBX_INSTR_D_BIT = 18;
  localparam int BBX_INSTR_OP_LSB = 20;

  // ---------------------------------------------------------------
  // status and config bits
  // ---------------------------------------------------------------
  localparam int BBX_ST_C_BIT = 0;
  localparam int BBX_ST_DIGIT_CARRY_BIT = 1;
  localparam int BBX_ST_Z_BIT = 2;
  localparam int BBX_ST_BUSY_BIT = 3;
  localparam int BBX_ST_DISC_BIT = 4;
  localparam int BBX_CFG_PSA_BIT = 0;

  // ---------------------------------------------------------------
  // file map, reset values, responses
  // ---------------------------------------------------------------
  localparam int BBX_FILE_AW = 7;
  localparam int BBX_FILE_DEPTH = 128;
  localparam logic [6:0] BBX_TIMER_ADDR = 7'h01;
  localparam logic [6:0] BBX_IO_PORT_ADDR = 7'h05;
  localparam logic [7:0] BBX_BYTE_RST = 8'h00;
  localparam logic [31:0] BBX_CYCLES_RST = 32'h0000_0000;
  localparam logic [1:0] BBX_RESP_OKAY = 2'b00;
  localparam logic [1:0] BBX_RESP_SLVERR = 2'b10;
  localparam logic BBX_DEST_W = 1'b0;

  typedef enum logic [3:0] {
    BBX_OP_NOP,
    BBX_OP_ADD_LIT,
    BBX_OP_AND_LIT,
    BBX_OP_ADD_REG,
    BBX_OP_AND_REG,
    BBX_OP_BIT_CLR,
    BBX_OP_BIT_SET,
    BBX_OP_SKIP_SET,
    BBX_OP_SKIP_CLR
  } bbx_op_t;

  typedef enum logic [1:0] {
    BBX_IDLE,
    BBX_EXEC,
    BBX_NOP
  } bbx_phase_t;

  // write one bit of a byte, used for set and clear
  function automatic logic [7:0] bbx_put_bit(input logic [7:0] v, input logic [2:0] idx,
                                             input logic val);
    logic [7:0] o;
    o = v;
    o[idx] = val;
    return o;
  endfunction : bbx_put_bit

endpackage : bbx_pkg

`default_nettype wire

/* File: logic/bbx_alu.sv */
`default_nettype none

// 8-bit add or and with flags
module bbx_alu (
  input wire logic and_sel,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] res,
  output logic carry,
  output logic dcarry,
  output logic zero
);

  logic [8:0] sum;
  logic [4:0] low;

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  // carry out of bit 7 and out of bit 3
  always_comb begin
    sum = {1'b0, a} + {1'b0, b};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    res = and_sel ? (a & b) : sum[7:0];
    carry = sum[8];
    dcarry = low[4];
    zero = (res == 8'h00);
  end

endmodule : bbx_alu

`default_nettype wire

/* File: logic/bbx_exec_top.sv */
`default_nettype none

// What this block does
// - a read-modify-write of the io port register takes the synced pin levels as operand.
// - writing a result into the timer zero count pulses a prescaler clear if it is assigned.
// - a skip that is taken lasts two cycles and the second one only advances the cycle count.
// - add literal adds the 8-bit literal to w, keeps the sum in w, updates all three flags.
// - bit clear zeroes bit b of file f and touches no flag; other bits keep their value, except on the io port, where they take the pin levels.
// - bit set forces bit b of file f to one and touches no flag; other bits keep their value, except on the io port, where they take the pin levels.
// - add register sums w and file f into the chosen destination, updating all three flags.
// - destination bit 0 sends a register result to w, 1 writes it back into file f.
// - and literal ands w with the literal into w and updates only z.
// - and register ands w with file f into the chosen destination, updating only z.
// - skip if set runs the next instruction on a zero bit and drops it on a one bit.
// - skip if clear runs the next instruction on a one bit and drops it on a zero bit.
module bbx_exec_top #(
  parameter logic [6:0] TIMER_ADDR = bbx_pkg::BBX_TIMER_ADDR,
  parameter logic [6:0] IO_PORT_ADDR = bbx_pkg::BBX_IO_PORT_ADDR
) (
  input wire logic clock,
  input wire logic rst_b,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // io port and timer side
  input wire logic [7:0] io_pins_in,
  output logic [7:0] io_port_out,
  output logic prescaler_clear,
  output logic busy
);

  typedef struct packed {
    bbx_pkg::bbx_phase_t phase;
    bbx_pkg::bbx_op_t op;
    logic [6:0] f;
    logic [2:0] b;
    logic d;
    logic [7:0] k;
    logic [7:0] w;
    logic c;
    logic digit_carry_flag;
    logic z;
    logic psa;
    logic discard;
    logic psc_clr;
    logic [bbx_pkg::BBX_FILE_DEPTH-1:0][7:0] mem;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] pins;
    logic aw_ok;
    logic [11:0] aw_addr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] cycles;
  } bbx_regs_t;

  bbx_regs_t r_reg;
  bbx_regs_t r_next;

  logic [7:0] operand;
  logic [7:0] alu_b;
  logic alu_and;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_digit_carry;
  logic alu_z;

  // ---------------------------------------------------------------
  // operand fetch and alu
  // ---------------------------------------------------------------
  // port reads see the pins, not the latch, so read-back of inputs is honest
  always_comb begin
    operand = (r_reg.f == IO_PORT_ADDR) ? r_reg.pins : r_reg.mem[r_reg.f];
    alu_b = (r_reg.op == bbx_pkg::BBX_OP_ADD_LIT || r_reg.op == bbx_pkg::BBX_OP_AND_LIT) ?
            r_reg.k : operand;
    alu_and = (r_reg.op == bbx_pkg::BBX_OP_AND_LIT || r_reg.op == bbx_pkg::BBX_OP_AND_REG);
  end

  bbx_alu u_alu (
    .and_sel(alu_and),
    .a(r_reg.w),
    .b(alu_b),
    .res(alu_res),
    .carry(alu_c),
    .dcarry(alu_digit_carry),
    .zero(alu_z)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic wr_file;
    logic [7:0] file_val;
    logic skip;
    logic [6:0] widx;
    wr_file = 1'b0;
    file_val = operand;
    skip = 1'b0;
    widx = r_reg.aw_addr[8:2];
    r_next = r_reg;
    r_next.psc_clr = 1'b0;

    // pin synchroniser: a change counts once stages two and three agree
    r_next.s1 = io_pins_in;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    if (r_reg.s2 == r_reg.s3) begin
      r_next.pins = r_reg.s3;
    end

    // execution sequencer
    unique case (r_reg.phase)
      bbx_pkg::BBX_IDLE: begin
      end
      bbx_pkg::BBX_EXEC: begin
        r_next.cycles = r_reg.cycles + 32'h0000_0001;
        r_next.phase = bbx_pkg::BBX_IDLE;
        unique case (r_reg.op)
          bbx_pkg::BBX_OP_ADD_LIT: begin
            r_next.w = alu_res;
            r_next.c = alu_c;
            r_next.digit_carry_flag = alu_digit_carry;
            r_next.z = alu_z;
          end
          bbx_pkg::BBX_OP_AND_LIT: begin
            r_next.w = alu_res;
            r_next.z = alu_z;
          end
          bbx_pkg::BBX_OP_ADD_REG: begin
            r_next.c = alu_c;
            r_next.digit_carry_flag = alu_digit_carry;
            r_next.z = alu_z;
            file_val = alu_res;
            if (r_reg.d == bbx_pkg::BBX_DEST_W) begin
              r_next.w = alu_res;
            end else begin
              wr_file = 1'b1;
            end
          end
          bbx_pkg::BBX_OP_AND_REG: begin
            r_next.z = alu_z;
            file_val = alu_res;
            if (r_reg.d == bbx_pkg::BBX_DEST_W) begin
              r_next.w = alu_res;
            end else begin
              wr_file = 1'b1;
            end
          end
          bbx_pkg::BBX_OP_BIT_CLR: begin
            file_val = bbx_pkg::bbx_put_bit(operand, r_reg.b, 1'b0);
            wr_file = 1'b1;
          end
          bbx_pkg::BBX_OP_BIT_SET: begin
            file_val = bbx_pkg::bbx_put_bit(operand, r_reg.b, 1'b1);
            wr_file = 1'b1;
          end
          bbx_pkg::BBX_OP_SKIP_SET: begin
            skip = operand[r_reg.b];
          end
          bbx_pkg::BBX_OP_SKIP_CLR: begin
            skip = ~operand[r_reg.b];
          end
          bbx_pkg::BBX_OP_NOP: begin
          end
          default: begin
          end
        endcase
        if (wr_file) begin
          r_next.mem[r_reg.f] = file_val;
          // timer count written: prescaler restarts only when it belongs to the timer
          if (r_reg.f == TIMER_ADDR && r_reg.psa) begin
            r_next.psc_clr = 1'b1;
          end
        end
        if (skip) begin
          r_next.phase = bbx_pkg::BBX_NOP;
          r_next.discard = 1'b1;
        end
      end
      bbx_pkg::BBX_NOP: begin
        // second cycle of a taken skip changes nothing but the cycle count
        r_next.cycles = r_reg.cycles + 32'h0000_0001;
        r_next.phase = bbx_pkg::BBX_IDLE;
      end
      default: begin
        r_next.phase = bbx_pkg::BBX_IDLE;
      end
    endcase

    // write address and data are caught independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      r_next.aw_ok = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_next.w_ok = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end

    // write commit; refused while busy so no field sees two writers
    if (r_reg.aw_ok && r_reg.w_ok && !r_reg.bvalid) begin
      r_next.aw_ok = 1'b0;
      r_next.w_ok = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = bbx_pkg::BBX_RESP_OKAY;
      if (r_reg.phase != bbx_pkg::BBX_IDLE) begin
        r_next.bresp = bbx_pkg::BBX_RESP_SLVERR;
      end else if (r_reg.aw_addr[11:9] == bbx_pkg::BBX_FILE_WIN_TOP) begin
        if (r_reg.wstrb[0]) begin
          r_next.mem[widx] = r_reg.wdata[7:0];
        end
      end else begin
        unique case (r_reg.aw_addr)
          bbx_pkg::BBX_OFS_INSTR: begin
            if (r_reg.discard) begin
              // instruction after a taken skip is dropped unexecuted
              r_next.discard = 1'b0;
            end else if (r_reg.wstrb != 4'h0) begin
              r_next.phase = bbx_pkg::BBX_EXEC;
              r_next.k = r_reg.wdata[bbx_pkg::BBX_INSTR_K_LSB +: 8];
              r_next.f = r_reg.wdata[bbx_pkg::BBX_INSTR_F_LSB +: 7];
              r_next.b = r_reg.wdata[bbx_pkg::BBX_INSTR_B_LSB +: 3];
              r_next.d = r_reg.wdata[bbx_pkg::BBX_INSTR_D_BIT];
              r_next.op = bbx_pkg::bbx_op_t'(r_reg.wdata[bbx_pkg::BBX_INSTR_OP_LSB +: 4]);
            end
          end
          bbx_pkg::BBX_OFS_W: begin
            if (r_reg.wstrb[0]) begin
              r_next.w = r_reg.wdata[7:0];
            end
          end
          bbx_pkg::BBX_OFS_STATUS: begin
            if (r_reg.wstrb[0]) begin
              r_next.c = r_reg.wdata[bbx_pkg::BBX_ST_C_BIT];
              r_next.digit_carry_flag = r_reg.wdata[bbx_pkg::BBX_ST_DIGIT_CARRY_BIT];
              r_next.z = r_reg.wdata[bbx_pkg::BBX_ST_Z_BIT];
              r_next.discard = r_reg.wdata[bbx_pkg::BBX_ST_DISC_BIT];
            end
          end
          bbx_pkg::BBX_OFS_CFG: begin
            if (r_reg.wstrb[0]) begin
              r_next.psa = r_reg.wdata[bbx_pkg::BBX_CFG_PSA_BIT];
            end
          end
          default: begin
            r_next.bresp = bbx_pkg::BBX_RESP_SLVERR;
          end
        endcase
      end
    end

    // read channel: one word answered the cycle after the address
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = bbx_pkg::BBX_RESP_OKAY;
      r_next.rdata = 32'h0000_0000;
      if (s_axi_araddr[11:9] == bbx_pkg::BBX_FILE_WIN_TOP) begin
        r_next.rdata[7:0] = r_reg.mem[s_axi_araddr[8:2]];
      end else begin
        unique case (s_axi_araddr)
          bbx_pkg::BBX_OFS_INSTR: begin
            r_next.rdata[bbx_pkg::BBX_INSTR_OP_LSB +: 4] = r_reg.op;
            r_next.rdata[bbx_pkg::BBX_INSTR_D_BIT] = r_reg.d;
            r_next.rdata[bbx_pkg::BBX_INSTR_B_LSB +: 3] = r_reg.b;
            r_next.rdata[bbx_pkg::BBX_INSTR_F_LSB +: 7] = r_reg.f;
            r_next.rdata[bbx_pkg::BBX_INSTR_K_LSB +: 8] = r_reg.k;
          end
          bbx_pkg::BBX_OFS_W: begin
            r_next.rdata[7:0] = r_reg.w;
          end
          bbx_pkg::BBX_OFS_STATUS: begin
            r_next.rdata[bbx_pkg::BBX_ST_C_BIT] = r_reg.c;
            r_next.rdata[bbx_pkg::BBX_ST_DIGIT_CARRY_BIT] = r_reg.digit_carry_flag;
            r_next.rdata[bbx_pkg::BBX_ST_Z_BIT] = r_reg.z;
            r_next.rdata[bbx_pkg::BBX_ST_BUSY_BIT] = (r_reg.phase != bbx_pkg::BBX_IDLE);
            r_next.rdata[bbx_pkg::BBX_ST_DISC_BIT] = r_reg.discard;
          end
          bbx_pkg::BBX_OFS_CFG: begin
            r_next.rdata[bbx_pkg::BBX_CFG_PSA_BIT] = r_reg.psa;
          end
          bbx_pkg::BBX_OFS_CYCLES: begin
            r_next.rdata = r_reg.cycles;
          end
          bbx_pkg::BBX_OFS_PINS: begin
            r_next.rdata[7:0] = r_reg.pins;
          end
          default: begin
            r_next.rresp = bbx_pkg::BBX_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // every field clears to zero: idle phase, nop op, empty file
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r_reg <= '0;
      r_reg.w <= bbx_pkg::BBX_BYTE_RST;
      r_reg.cycles <= bbx_pkg::BBX_CYCLES_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // handshakes combinational, data from flops
  assign s_axi_awready = !r_reg.aw_ok && !r_reg.bvalid;
  assign s_axi_wready = !r_reg.w_ok && !r_reg.bvalid;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = !r_reg.rvalid;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign io_port_out = r_reg.mem[IO_PORT_ADDR]; // output latch, not the pins
  assign prescaler_clear = r_reg.psc_clr;
  assign busy = (r_reg.phase != bbx_pkg::BBX_IDLE);

endmodule : bbx_exec_top

`default_nettype wire

/* File: test/bbx_exec_props.sv */
`default_nettype none

// ---------------------------------------------------------------
// port-level checks of the execution block
// ---------------------------------------------------------------
module bbx_exec_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic prescaler_clear,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // bus answers and holds; the pair is held one cycle before it commits
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ar_gate_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
  // unmapped read answers an error with zero data
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h018
    |=> s_axi_rresp == bbx_pkg::BBX_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  // an instruction lasts one cycle, two when a skip is taken
  busy_len_a: assert property (busy ##1 busy |=> !busy) else $error("busy too long");
  busy_start_a: assert property ($rose(busy) |-> $rose(s_axi_bvalid))
    else $error("busy without accepted write");
  clr_pulse_a: assert property (prescaler_clear |=> !prescaler_clear)
    else $error("prescaler clear too long");
  clr_cause_a: assert property (prescaler_clear |-> $past(busy))
    else $error("prescaler clear without instruction");

  skip_c: cover property (busy ##1 busy);
  clr_c: cover property (prescaler_clear);
  refuse_c: cover property (s_axi_bvalid && s_axi_bresp == bbx_pkg::BBX_RESP_SLVERR);
endmodule : bbx_exec_props

`default_nettype wire

/* File: test/testbench.sv */
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] io_pins_in = 8'h00;
  logic [7:0] io_port_out;
  logic prescaler_clear, busy;
  int err_count = 0;
  int samples_checked = 0;
  int busy_n = 0;
  int pclr_n = 0;

  bbx_exec_top dut (
    .clock(clock), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .io_pins_in(io_pins_in), .io_port_out(io_port_out),
    .prescaler_clear(prescaler_clear), .busy(busy)
  );

  always #5 clock = ~clock;

  // busy cycles and clear pulses are counted as the edges see them
  always @(posedge clock) begin
    if (busy === 1'b1) busy_n++;
    if (prescaler_clear === 1'b1) pclr_n++;
  end

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  // a hang ends the run rather than stalling it
  task automatic to(input int n);
    if (n >= 40) begin
      $display("unexpected handshake expected answer seen timeout");
      err_count++;
      tally_and_finish();
    end
  endtask : to

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    to(n);
    chk("bresp", (a == 12'h018) ? 32'h2 : 32'h0, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    to(n);
    chk("rresp", (a == 12'h018) ? 32'h2 : 32'h0, {30'h0, s_axi_rresp});
  endtask : rd

  function automatic logic [11:0] fa(input logic [6:0] f);
    return 12'h200 + {3'h0, f, 2'b00};
  endfunction : fa

  // issue one instruction; three edges cover even a taken skip
  task automatic ex(input logic [3:0] op, input logic [6:0] f, input logic [2:0] b,
                    input logic d, input logic [7:0] k);
    wr(12'h000, {8'h00, op, 1'b0, d, b, f, k});
    repeat (3) @(posedge clock);
  endtask : ex

  task automatic see(input string nm, input logic [11:0] a, input logic [31:0] e);
    rd(a, rv);
    chk(nm, e, rv);
  endtask : see

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_alu;
    see("w reset", 12'h004, 32'h0);
    see("unmapped", 12'h018, 32'h0);
    wr(12'h018, 32'h5a);
    wr(12'h004, 32'h88);
    ex(4'h1, 7'h00, 3'h0, 1'b0, 8'h78);
    see("w", 12'h004, 32'h00);
    see("flags", 12'h008, 32'h7);
    ex(4'h1, 7'h00, 3'h0, 1'b0, 8'h01);
    see("flags", 12'h008, 32'h0);
    wr(12'h008, 32'h3);
    ex(4'h2, 7'h00, 3'h0, 1'b0, 8'h0e);
    see("flags", 12'h008, 32'h7);
    wr(12'h004, 32'hf0);
    wr(fa(7'h20), 32'h3c);
    ex(4'h4, 7'h20, 3'h0, 1'b0, 8'h00);
    see("w", 12'h004, 32'h30);
    see("file", fa(7'h20), 32'h3c);
    see("flags", 12'h008, 32'h3);
    ex(4'h4, 7'h20, 3'h0, 1'b1, 8'h00);
    see("file", fa(7'h20), 32'h30);
    wr(12'h004, 32'h0f);
    wr(fa(7'h7f), 32'h01);
    wr(12'h008, 32'h0);
    ex(4'h3, 7'h7f, 3'h0, 1'b1, 8'h00);
    see("file", fa(7'h7f), 32'h10);
    see("w", 12'h004, 32'h0f);
    see("flags", 12'h008, 32'h2);
    ex(4'h3, 7'h7f, 3'h0, 1'b0, 8'h00);
    see("w", 12'h004, 32'h1f);
    $display("done alu");
  endtask : t_alu

  task automatic t_bits;
    wr(fa(7'h00), 32'hff);
    wr(12'h008, 32'h5);
    ex(4'h5, 7'h00, 3'h7, 1'b0, 8'h00);
    see("file", fa(7'h00), 32'h7f);
    ex(4'h6, 7'h7f, 3'h0, 1'b0, 8'h00);
    see("file", fa(7'h7f), 32'h11);
    ex(4'h0, 7'h00, 3'h0, 1'b0, 8'h00);
    see("flags", 12'h008, 32'h5);
    $display("done bits");
  endtask : t_bits

  task automatic t_skip;
    logic [3:0] ops [4] = '{4'h7, 4'h7, 4'h8, 4'h8};
    logic [2:0] bs [4] = '{3'h2, 3'h0, 3'h0, 3'h2};
    int w;
    int n0;
    w = 0;
    wr(fa(7'h30), 32'h04);
    wr(12'h004, 32'h0);
    for (int i = 0; i < 4; i++) begin
      n0 = busy_n;
      ex(ops[i], 7'h30, bs[i], 1'b0, 8'h00);
      chk("busy cycles", (i % 2 == 0) ? 2 : 1, busy_n - n0);
      ex(4'h1, 7'h00, 3'h0, 1'b0, 8'h01);
      w = w + i % 2;
      see("w", 12'h004, w);
    end
    // 10 single-cycle ops, 4 tests, 2 taken-skip fillers, 2 adds kept
    see("cycles", 12'h010, 32'h12);
    $display("done skip");
  endtask : t_skip

  task automatic t_timer;
    int p0;
    p0 = pclr_n;
    wr(12'h00c, 32'h1);
    ex(4'h6, 7'h01, 3'h3, 1'b0, 8'h00);
    ex(4'h4, 7'h01, 3'h0, 1'b0, 8'h00);
    wr(12'h00c, 32'h0);
    ex(4'h6, 7'h01, 3'h4, 1'b0, 8'h00);
    chk("clear pulses", 1, pclr_n - p0);
    $display("done timer");
  endtask : t_timer

  task automatic t_io;
    @(posedge clock);
    io_pins_in <= 8'ha5;
    wr(fa(7'h05), 32'h0f);
    repeat (5) @(posedge clock);
    ex(4'h6, 7'h05, 3'h6, 1'b0, 8'h00);
    chk("io latch", 32'he5, {24'h0, io_port_out});
    see("pins", 12'h014, 32'ha5);
    $display("done io");
  endtask : t_io

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    t_alu();
    t_bits();
    t_skip();
    t_timer();
    t_io();
    tally_and_finish();
  end
endmodule : testbench

bind bbx_exec_top bbx_exec_props u_props (
  .clock(clock), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .prescaler_clear(prescaler_clear), .busy(busy)
);

`default_nettype wire
